// file: fp_store_pkg.sv
// Contract
// - Block store writes eight doubles, ascending addresses.
// - In-progress doublewords show old, zero or new.
// - Only each 8-byte portion is atomic.
// - Commit variant writes through, invalidates all caches.
// - Two commit identifiers select only commit block store.
// - Register interlocks not required for block store.
// - Unordered non-cacheable block store traps illegal.
// - Watchpoint covers all 64 bytes or first eight.
// - Block source register not eight-aligned traps illegal.
// - Float disabled or absent traps float-off.
// - Block address low six bits nonzero misaligns.
// - Unprivileged block store, identifier bit7 clear, traps.
// - Single/double/quad widths; word atomicity for wide.
// - Address is rs1 plus rs2 or immediate.
// - Register form with bits 12:5 set traps illegal.
// - Non word-aligned address traps misaligned.
// - Word- not doubleword-aligned double gets dedicated trap.
// - Quad store always traps illegal for emulation.
// - Shared opcode decoded by address-space identifier.
package fp_store_pkg;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0]  CTRL_OFS       = 8'h00;
  localparam logic [7:0]  WATCH_LO_OFS   = 8'h04;
  localparam logic [7:0]  WATCH_HI_OFS   = 8'h08;
  localparam logic [7:0]  STATUS_OFS     = 8'h0c;
  localparam logic [7:0]  STORE_CNT_OFS  = 8'h10;

  // ==========================================================
  // Control field positions and reset value
  localparam int          CTRL_FPU_BIT   = 0;     // Float unit present
  localparam int          CTRL_NCORD_BIT = 1;     // Non-cacheable block in order
  localparam int          CTRL_WALL_BIT  = 2;     // Watch all 64 bytes
  localparam int          CTRL_WEN_BIT   = 3;     // Watchpoint enable
  localparam logic [3:0]  CTRL_RESET     = 4'h7;
  localparam int          STATUS_BUSY_BIT = 8;

  // ==========================================================
  // Block transfer geometry and address-space identifiers
  localparam logic [3:0]  BLOCK_BEATS     = 4'h8;
  localparam int          BLOCK_ALIGN_BITS = 6;
  localparam logic [63:0] DW_BYTES        = 64'h8;
  localparam logic [5:0]  DBL_REG_STEP    = 6'h2;
  localparam logic [7:0]  ASI_COMMIT_P    = 8'he0;
  localparam logic [7:0]  ASI_COMMIT_S    = 8'he1;
  localparam logic [7:0]  ASI_BLK_AIUP    = 8'h16;
  localparam logic [7:0]  ASI_BLK_AIUS    = 8'h17;
  localparam logic [7:0]  ASI_BLK_AIUPL   = 8'h1e;
  localparam logic [7:0]  ASI_BLK_AIUSL   = 8'h1f;
  localparam int          ASI_PRIV_BIT    = 7;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    OP_SINGLE, OP_DOUBLE, OP_QUAD, OP_SHARED_ALT
  } op_e;

  typedef enum logic [2:0] {
    RES_OK         = 3'h0,
    RES_ILLEGAL    = 3'h1,
    RES_FLOAT_OFF  = 3'h2,
    RES_PRIV       = 3'h3,
    RES_MISALIGN   = 3'h4,
    RES_DBL_MISAL  = 3'h5,
    RES_WATCH      = 3'h6,
    RES_OTHER_UNIT = 3'h7
  } result_e;

  typedef struct packed {
    op_e         op;        // Store flavour
    logic        imm;       // Immediate form
    logic [12:0] low_bits;  // Instruction bits 12:0
    logic [4:0]  rd;        // Encoded source register
    logic [7:0]  asi;       // Resolved address-space identifier
    logic [63:0] rs1_val;   // First address operand
    logic [63:0] rs2_val;   // Second address operand
  } issue_req_s;

  typedef struct packed {
    logic [63:0] addr;      // Doubleword-aligned address
    logic [63:0] data;      // Big-endian lane data
    logic [7:0]  be;        // Byte enables, bit7 = lowest address
    logic        commit;    // Write through and invalidate caches
    logic        last;      // Final beat of the instruction
  } mem_wr_s;

endpackage

// file: fp_store_exec.sv
// Implementation choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
module fp_store_exec
  import fp_store_pkg::*;
(
  input  wire logic        MCLK,
  input  wire logic        RESETN,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [31:0] WB_DAT_I,
  input  wire logic        WB_WE_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_CYC_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic        ISSUE_VALID,
  input  wire issue_req_s  ISSUE_REQ,
  output logic             ISSUE_READY,
  input  wire logic        FLOAT_ENABLE_BIT,
  input  wire logic        PROC_STATE_FLOAT_ENABLE,
  input  wire logic        PRIVILEGED_MODE_BIT,
  input  wire logic        PAGE_CACHEABLE_BIT,
  output logic      [5:0]  FPR_RD_IDX,
  input  wire logic [63:0] FPR_RD_DATA,
  output logic             MEM_WR_VALID,
  output mem_wr_s          MEM_WR,
  input  wire logic        MEM_WR_READY,
  output logic             RESULT_VALID,
  output result_e          RESULT_CODE
);

  // ==========================================================
  // Declarations
  typedef enum {S_IDLE, S_CHECK, S_FETCH, S_WRITE} state_e;

  state_e      state_ff;                 // Sequencer state
  issue_req_s  req_ff;                   // Latched instruction
  logic [3:0]  ctrl_ff;                  // Control bits
  logic [63:0] watch_ff;                 // Watch virtual address
  logic [31:0] store_cnt_ff;             // Completed stores
  result_e     last_res_ff;              // Last reported result
  logic [3:0]  beat_ff;                  // Beat index within block
  logic [5:0]  idx_ff;                   // Register read index
  logic        ready_ff;                 // Issue accept
  mem_wr_s     wr_ff;                    // Outgoing write
  logic        wr_valid_ff;              // Outgoing write valid
  logic        res_valid_ff;             // Result pulse
  result_e     res_code_ff;              // Result code
  logic [31:0] dat_o_ff;                 // Bus read data
  logic        ack_ff;                   // Bus acknowledge

  // ==========================================================
  // Effective address and decode
  wire [63:0] offs_w     = req_ff.imm ? {{51{req_ff.low_bits[12]}}, req_ff.low_bits}
                                      : req_ff.rs2_val;
  wire [63:0] ea_w       = req_ff.rs1_val + offs_w;
  // Shared opcode split by identifier
  wire        commit_w   = (req_ff.asi == ASI_COMMIT_P) || (req_ff.asi == ASI_COMMIT_S);
  wire        blk_asi_w  = commit_w || (req_ff.asi == ASI_BLK_AIUP) || (req_ff.asi == ASI_BLK_AIUS)
                        || (req_ff.asi == ASI_BLK_AIUPL) || (req_ff.asi == ASI_BLK_AIUSL);
  wire        is_block_w = (req_ff.op == OP_SHARED_ALT) && blk_asi_w;
  wire        is_other_w = (req_ff.op == OP_SHARED_ALT) && !blk_asi_w;
  wire        is_sgl_w   = (req_ff.op == OP_SINGLE);
  wire        is_dbl_w   = (req_ff.op == OP_DOUBLE);
  wire        is_quad_w  = (req_ff.op == OP_QUAD);
  // Double register number from the encoded field
  wire [5:0]  dreg_w     = {req_ff.rd[0], req_ff.rd[4:1], 1'b0};

  // ==========================================================
  // Trap conditions
  wire ill_enc_w  = (is_sgl_w || is_dbl_w) && !req_ff.imm
                    && (req_ff.low_bits[12:5] != 8'h00);
  wire ill_rd_w   = is_block_w && (dreg_w[3:0] != 4'h0);
  wire fp_off_w   = !FLOAT_ENABLE_BIT || !PROC_STATE_FLOAT_ENABLE
                    || !ctrl_ff[CTRL_FPU_BIT];
  wire priv_w     = is_block_w && !PRIVILEGED_MODE_BIT
                    && !req_ff.asi[ASI_PRIV_BIT];
  wire blk_mis_w  = is_block_w && (ea_w[BLOCK_ALIGN_BITS-1:0] != 6'h00);
  wire word_mis_w = (is_sgl_w || is_dbl_w) && (ea_w[1:0] != 2'h0);
  wire dbl_mis_w  = is_dbl_w && ea_w[2];
  wire nc_ill_w   = is_block_w && !PAGE_CACHEABLE_BIT
                    && !ctrl_ff[CTRL_NCORD_BIT];
  // Whole block or first doubleword only
  wire watch_hit_w = ctrl_ff[CTRL_WEN_BIT] && (is_block_w && ctrl_ff[CTRL_WALL_BIT]
                     ? (ea_w[63:6] == watch_ff[63:6])
                     : (ea_w[63:3] == watch_ff[63:3]));

  // Single prioritised verdict
  result_e sel_code_w;
  always_comb begin
    if (is_quad_w || ill_enc_w || ill_rd_w) begin
      sel_code_w = RES_ILLEGAL;
    end else if (is_other_w) begin
      sel_code_w = RES_OTHER_UNIT;
    end else if (fp_off_w) begin
      sel_code_w = RES_FLOAT_OFF;
    end else if (priv_w) begin
      sel_code_w = RES_PRIV;
    end else if (blk_mis_w || word_mis_w) begin
      sel_code_w = RES_MISALIGN;
    end else if (dbl_mis_w) begin
      sel_code_w = RES_DBL_MISAL;
    end else if (nc_ill_w) begin
      sel_code_w = RES_ILLEGAL;
    end else if (watch_hit_w) begin
      sel_code_w = RES_WATCH;
    end else begin
      sel_code_w = RES_OK;
    end
  end

  // ==========================================================
  // Beat formatting
  wire [3:0]  last_beat_w = is_block_w ? BLOCK_BEATS - 4'h1 : 4'h0;
  wire        last_w      = (beat_ff == last_beat_w);
  // Block beats ascend from the aligned base
  wire [63:0] beat_addr_w = {ea_w[63:3], 3'h0} + (DW_BYTES * {60'h0, beat_ff});
  // Single goes to the word lane chosen by address bit 2
  wire [7:0]  beat_be_w   = is_sgl_w ? (ea_w[2] ? 8'h0f : 8'hf0) : 8'hff;
  wire [63:0] beat_data_w = is_sgl_w ? {2{FPR_RD_DATA[31:0]}} : FPR_RD_DATA;
  wire [5:0]  first_idx_w = is_sgl_w ? {1'b0, req_ff.rd} : dreg_w;
  wire        wr_done_w   = wr_valid_ff && MEM_WR_READY;
  wire        accept_w    = ISSUE_VALID && ready_ff;

  // ==========================================================
  // Sequencer: one 8-byte write per beat, no interlock tracking
  state_e nxt_state;
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      S_IDLE:  if (accept_w) begin
        nxt_state = S_CHECK;
      end
      S_CHECK: nxt_state = (sel_code_w == RES_OK) ? S_FETCH : S_IDLE;
      S_FETCH: nxt_state = S_WRITE;
      S_WRITE: if (wr_done_w) begin
        nxt_state = last_w ? S_IDLE : S_FETCH;
      end
      default: nxt_state = S_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      state_ff <= S_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Instruction latch and issue handshake
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      req_ff   <= '0;
      ready_ff <= 1'b1;
    end else begin
      if (accept_w) begin
        req_ff <= ISSUE_REQ;
      end
      ready_ff <= (nxt_state == S_IDLE);
    end
  end

  // Register index and beat counter
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      beat_ff <= 4'h0;
      idx_ff  <= 6'h00;
    end else if (state_ff == S_CHECK) begin
      beat_ff <= 4'h0;
      idx_ff  <= first_idx_w;
    end else if (state_ff == S_WRITE && wr_done_w) begin
      beat_ff <= beat_ff + 4'h1;
      idx_ff  <= idx_ff + DBL_REG_STEP;
    end
  end

  // Write beat: whole doubleword per block or double beat, one word lane for single, no zero fill
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      wr_ff       <= '0;
      wr_valid_ff <= 1'b0;
    end else if (state_ff == S_FETCH) begin
      wr_ff.addr   <= beat_addr_w;
      wr_ff.data   <= beat_data_w;
      wr_ff.be     <= beat_be_w;
      wr_ff.commit <= is_block_w && commit_w;
      wr_ff.last   <= last_w;
      wr_valid_ff  <= 1'b1;
    end else if (wr_done_w) begin
      wr_valid_ff  <= 1'b0;
    end
  end

  // Result pulse, status and counter
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      res_valid_ff <= 1'b0;
      res_code_ff  <= RES_OK;
      last_res_ff  <= RES_OK;
      store_cnt_ff <= 32'h0;
    end else begin
      res_valid_ff <= 1'b0;
      if (state_ff == S_CHECK && sel_code_w != RES_OK) begin
        res_valid_ff <= 1'b1;
        res_code_ff  <= sel_code_w;
        last_res_ff  <= sel_code_w;
      end else if (state_ff == S_WRITE && wr_done_w && last_w) begin
        res_valid_ff <= 1'b1;
        res_code_ff  <= RES_OK;
        last_res_ff  <= RES_OK;
        store_cnt_ff <= store_cnt_ff + 32'h1;
      end
    end
  end

  // ==========================================================
  // Wishbone slave: one wait state, unmapped reads zero
  wire        req_w    = WB_CYC_I && WB_STB_I && !ack_ff;
  wire        wr_w     = req_w && WB_WE_I;
  wire        hit_ctrl = (WB_ADR_I == CTRL_OFS);
  wire        hit_wlo  = (WB_ADR_I == WATCH_LO_OFS);
  wire        hit_whi  = (WB_ADR_I == WATCH_HI_OFS);
  wire [31:0] status_w = {23'h0, (state_ff != S_IDLE), 5'h0, last_res_ff};
  wire [31:0] rd_mux_w = hit_ctrl ? {28'h0, ctrl_ff}
                       : hit_wlo  ? watch_ff[31:0]
                       : hit_whi  ? watch_ff[63:32]
                       : (WB_ADR_I == STATUS_OFS)    ? status_w
                       : (WB_ADR_I == STORE_CNT_OFS) ? store_cnt_ff
                       : 32'h0;

  // Acknowledge and read data
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      ack_ff   <= 1'b0;
      dat_o_ff <= 32'h0;
    end else begin
      ack_ff   <= req_w;
      dat_o_ff <= req_w ? rd_mux_w : 32'h0;
    end
  end

  // Control register, low byte lane only
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      ctrl_ff <= CTRL_RESET;
    end else if (wr_w && hit_ctrl && WB_SEL_I[0]) begin
      ctrl_ff <= WB_DAT_I[3:0];
    end
  end

  // Watch address, byte lanes per word
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_watch
      always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
          watch_ff[8*g +: 8]      <= 8'h00;
          watch_ff[32 + 8*g +: 8] <= 8'h00;
        end else if (wr_w && WB_SEL_I[g]) begin
          if (hit_wlo) begin
            watch_ff[8*g +: 8] <= WB_DAT_I[8*g +: 8];
          end
          if (hit_whi) begin
            watch_ff[32 + 8*g +: 8] <= WB_DAT_I[8*g +: 8];
          end
        end
      end
    end
  endgenerate

  // ==========================================================
  // Outputs
  assign WB_DAT_O     = dat_o_ff;
  assign WB_ACK_O     = ack_ff;
  assign ISSUE_READY  = ready_ff;
  assign FPR_RD_IDX   = idx_ff;
  assign MEM_WR_VALID = wr_valid_ff;
  assign MEM_WR       = wr_ff;
  assign RESULT_VALID = res_valid_ff;
  assign RESULT_CODE  = res_code_ff;

  // ==========================================================
  // Assertions
  wire in_check = (state_ff == S_CHECK);

  a_trap_no_write: assert property (@(posedge MCLK) disable iff (!RESETN)
    (in_check && sel_code_w != RES_OK) |=> (RESULT_VALID && RESULT_CODE == $past(sel_code_w))
      ##1 (!MEM_WR_VALID)[*2])
    else $error("trap issued but write followed");

  a_quad_illegal: assert property (@(posedge MCLK) disable iff (!RESETN)
    (in_check && is_quad_w) |=> (RESULT_VALID && RESULT_CODE == RES_ILLEGAL))
    else $error("quad store not illegal");

  a_block_rd_align: assert property (@(posedge MCLK) disable iff (!RESETN)
    (in_check && is_block_w && dreg_w[3:0] != 4'h0) |=> (RESULT_CODE == RES_ILLEGAL))
    else $error("unaligned block register accepted");

  a_block_misalign: assert property (@(posedge MCLK) disable iff (!RESETN)
    (in_check && is_block_w && !ill_rd_w && !fp_off_w && !priv_w && ea_w[5:0] != 6'h00)
      |=> (RESULT_VALID && RESULT_CODE == RES_MISALIGN))
    else $error("misaligned block accepted");

  a_float_off: assert property (@(posedge MCLK) disable iff (!RESETN)
    (in_check && fp_off_w && !is_quad_w && !is_other_w && !ill_enc_w && !ill_rd_w)
      |=> (RESULT_CODE == RES_FLOAT_OFF))
    else $error("float-off trap missing");

  a_dbl_misalign: assert property (@(posedge MCLK) disable iff (!RESETN)
    (in_check && is_dbl_w && ea_w[2:0] == 3'h4 && !ill_enc_w && !fp_off_w)
      |=> (RESULT_CODE == RES_DBL_MISAL))
    else $error("double misalign trap missing");

  a_block_ascend: assert property (@(posedge MCLK) disable iff (!RESETN)
    (wr_done_w && !MEM_WR.last) |=> !MEM_WR_VALID
      ##1 (MEM_WR_VALID && MEM_WR.addr == $past(MEM_WR.addr, 2) + DW_BYTES))
    else $error("block beats not ascending by eight");

  a_commit_only: assert property (@(posedge MCLK) disable iff (!RESETN)
    (MEM_WR_VALID && MEM_WR.commit) |-> (is_block_w && commit_w))
    else $error("commit on non-commit store");

  a_ea_first: assert property (@(posedge MCLK) disable iff (!RESETN)
    (MEM_WR_VALID && beat_ff == 4'h0) |-> (MEM_WR.addr[63:3] == ea_w[63:3]))
    else $error("first beat address wrong");

  // Register form with junk in the spare field
  a_reg_form_enc: assert property (@(posedge MCLK) disable iff (!RESETN)
    (in_check && (is_sgl_w || is_dbl_w) && !req_ff.imm && req_ff.low_bits[12:5] != 8'h00)
      |=> (RESULT_VALID && RESULT_CODE == RES_ILLEGAL))
    else $error("register form junk not illegal");

  // Word misalignment on single and double
  a_word_misalign: assert property (@(posedge MCLK) disable iff (!RESETN)
    (in_check && (is_sgl_w || is_dbl_w) && !ill_enc_w && !fp_off_w && ea_w[1:0] != 2'h0)
      |=> (RESULT_VALID && RESULT_CODE == RES_MISALIGN))
    else $error("word misaligned store accepted");

  // Unprivileged block store to a low identifier
  a_block_priv: assert property (@(posedge MCLK) disable iff (!RESETN)
    (in_check && is_block_w && !ill_rd_w && !fp_off_w && !PRIVILEGED_MODE_BIT && !req_ff.asi[ASI_PRIV_BIT])
      |=> (RESULT_VALID && RESULT_CODE == RES_PRIV))
    else $error("privileged action trap missing");

  // Unordered non-cacheable block store
  a_nc_unordered: assert property (@(posedge MCLK) disable iff (!RESETN)
    (in_check && nc_ill_w && !ill_rd_w && !fp_off_w && !priv_w && !blk_mis_w)
      |=> (RESULT_VALID && RESULT_CODE == RES_ILLEGAL))
    else $error("non-cacheable block store not illegal");

  // Shared opcode with a non-block identifier goes elsewhere
  a_shared_split: assert property (@(posedge MCLK) disable iff (!RESETN)
    (in_check && is_other_w) |=> (RESULT_VALID && RESULT_CODE == RES_OTHER_UNIT))
    else $error("shared opcode not handed over");

  // Single and double stores are one beat
  a_one_beat_word: assert property (@(posedge MCLK) disable iff (!RESETN)
    (MEM_WR_VALID && !is_block_w) |-> MEM_WR.last)
    else $error("word store took several beats");

  // Main scenarios
  c_other_unit: cover property (@(posedge MCLK) disable iff (!RESETN)
    RESULT_VALID && RESULT_CODE == RES_OTHER_UNIT);
  c_block_done: cover property (@(posedge MCLK) disable iff (!RESETN)
    MEM_WR_VALID && MEM_WR.commit && MEM_WR.last && MEM_WR_READY);
  c_single_ok: cover property (@(posedge MCLK) disable iff (!RESETN)
    in_check && is_sgl_w ##3 (RESULT_VALID && RESULT_CODE == RES_OK));
  c_watch_trap: cover property (@(posedge MCLK) disable iff (!RESETN)
    RESULT_VALID && RESULT_CODE == RES_WATCH);

endmodule
`default_nettype wire

// file: fp_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module fp_mem_model
  import fp_store_pkg::*;
(
  input  wire logic        MCLK,
  input  wire logic        RESETN,
  input  wire logic        stall_en,
  input  wire logic [5:0]  fpr_rd_idx,
  output logic      [63:0] fpr_rd_data,
  input  wire logic        mem_wr_valid,
  input  wire mem_wr_s     mem_wr,
  output logic             mem_wr_ready
);
  // ==========================================================
  // Register file and memory side
  mem_wr_s got_q[$];  // Accepted beats, in arrival order

  // Register file read: index pattern in both halves
  assign fpr_rd_data = {16'hd0d0, 10'h000, fpr_rd_idx, 16'h5a5a, 10'h000, fpr_rd_idx};

  // Ready stalls at random when asked; each beat is one whole write
  // Beats are logged as they come, with no ordering against other traffic
  always @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      mem_wr_ready <= 1'b0;
    end else begin
      mem_wr_ready <= stall_en ? 1'($urandom) : 1'b1;
      if (mem_wr_valid && mem_wr_ready) begin
        got_q.push_back(mem_wr);
      end
    end
  end
endmodule
`default_nettype wire

// file: fp_store_exec_and_trap_check_tb.sv
`timescale 1ns/10ps
`default_nettype none
module fp_store_exec_and_trap_check_tb;
  import fp_store_pkg::*;
  // ==========================================================
  // Stimulus and observed signals
  logic        MCLK = 1'b0;
  logic        RESETN = 1'b0;
  logic [7:0]  wb_adr = '0;
  logic [31:0] wb_dat = '0;
  logic        wb_we = 1'b0;
  logic [3:0]  wb_sel = '0;
  logic        wb_stb = 1'b0;
  logic        wb_cyc = 1'b0;
  logic [31:0] wb_rdat;
  logic        wb_ack;
  logic        iss_valid = 1'b0;
  issue_req_s  iss_req = '0;
  logic        iss_ready;
  logic        fef = 1'b1;
  logic        pef = 1'b1;
  logic        priv = 1'b1;
  logic        cacheable = 1'b1;
  logic        stall = 1'b0;
  logic [5:0]  fpr_idx;
  logic [63:0] fpr_data;
  logic        mw_valid;
  mem_wr_s     mw;
  logic        mw_ready;
  logic        res_valid;
  result_e     res_code;
  int          fails = 0;
  int          total_checks = 0;
  int          cycles = 0;
  int          ok_cnt = 0;
  issue_req_s  r;
  logic [31:0] q;
  logic [63:0] wa;

  always #2.5 MCLK = ~MCLK;

  fp_store_exec u_dut (.MCLK(MCLK), .RESETN(RESETN), .WB_ADR_I(wb_adr), .WB_DAT_I(wb_dat), .WB_WE_I(wb_we),
    .WB_SEL_I(wb_sel), .WB_STB_I(wb_stb), .WB_CYC_I(wb_cyc), .WB_DAT_O(wb_rdat), .WB_ACK_O(wb_ack),
    .ISSUE_VALID(iss_valid), .ISSUE_REQ(iss_req), .ISSUE_READY(iss_ready), .FLOAT_ENABLE_BIT(fef),
    .PROC_STATE_FLOAT_ENABLE(pef), .PRIVILEGED_MODE_BIT(priv), .PAGE_CACHEABLE_BIT(cacheable),
    .FPR_RD_IDX(fpr_idx), .FPR_RD_DATA(fpr_data), .MEM_WR_VALID(mw_valid), .MEM_WR(mw),
    .MEM_WR_READY(mw_ready), .RESULT_VALID(res_valid), .RESULT_CODE(res_code));

  fp_mem_model u_mem (.MCLK(MCLK), .RESETN(RESETN), .stall_en(stall), .fpr_rd_idx(fpr_idx),
    .fpr_rd_data(fpr_data), .mem_wr_valid(mw_valid), .mem_wr(mw), .mem_wr_ready(mw_ready));

  // ==========================================================
  // Verdict, timeout and comparison
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge MCLK) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      fails++;
      print_verdict();
    end
  end

  // Case-equal compare with report
  task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // ==========================================================
  // Bus cycle and store issue
  task automatic wb(input logic [7:0] a, input logic we, input logic [31:0] d, output logic [31:0] rd);
    wb_adr <= a;
    wb_we <= we;
    wb_dat <= d;
    wb_sel <= 4'hf;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    do @(posedge MCLK); while (wb_ack !== 1'b1);
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge MCLK);
  endtask

  // Expected beat k of a store
  function automatic mem_wr_s exp_beat(issue_req_s s, logic [63:0] ea, int k);
    mem_wr_s e;
    logic [5:0] i;
    i = (s.op == OP_SINGLE) ? {1'b0, s.rd} : {s.rd[0], s.rd[4:1], 1'b0} + 6'(2 * k);
    e.addr = {ea[63:3], 3'h0} + 64'(8 * k);
    e.data = {16'hd0d0, 10'h000, i, 16'h5a5a, 10'h000, i};
    e.be = 8'hff;
    e.commit = s.op == OP_SHARED_ALT && s.asi[7:1] == 7'h70;
    e.last = s.op != OP_SHARED_ALT || k == 7;
    if (s.op == OP_SINGLE) begin
      e.be = ea[2] ? 8'h0f : 8'hf0;
      e.data = ea[2] ? {32'h0, e.data[31:0]} : {e.data[31:0], 32'h0};
    end
    return e;
  endfunction

  // Issue one store, wait for its result, compare result and beats
  task automatic run(input issue_req_s s, input result_e exp);
    logic [63:0] ea;
    logic [63:0] m;
    mem_wr_s e;
    mem_wr_s b;
    int nb;
    ea = s.rs1_val + (s.imm ? {{51{s.low_bits[12]}}, s.low_bits} : s.rs2_val);
    u_mem.got_q.delete();
    iss_req <= s;
    iss_valid <= 1'b1;
    do @(posedge MCLK); while (iss_ready !== 1'b1);
    iss_valid <= 1'b0;
    do @(posedge MCLK); while (res_valid !== 1'b1);
    check(res_code, exp, "result code");
    nb = (exp != RES_OK) ? 0 : (s.op == OP_SHARED_ALT) ? 8 : 1;
    ok_cnt += (exp == RES_OK);
    check(64'(u_mem.got_q.size()), 64'(nb), "beat count");
    for (int k = 0; k < nb && k < u_mem.got_q.size(); k++) begin
      e = exp_beat(s, ea, k);
      b = u_mem.got_q[k];
      for (int j = 0; j < 8; j++) m[8*j +: 8] = {8{e.be[j]}};
      check(b.addr, e.addr, "beat address");
      check(b.data & m, e.data & m, "beat data");
      check({b.be, b.commit, b.last}, {e.be, e.commit, e.last}, "beat flags");
    end
  endtask

  // Random store with aligned address and legal encoding
  function automatic issue_req_s rnd_req(op_e op);
    issue_req_s s;
    s.op = op;
    s.imm = 1'($urandom);
    s.rd = 5'($urandom);
    s.asi = 8'h80;
    s.rs1_val = {32'($urandom), 32'($urandom)} & ~64'h7;
    s.rs2_val = {32'($urandom), 32'($urandom)} & ~64'h7;
    s.low_bits = s.imm ? 13'($urandom) & 13'h1ff8 : 13'($urandom) & 13'h001f;
    return s;
  endfunction

  // Legal block store with given identifier
  function automatic issue_req_s blk(logic [7:0] asi);
    issue_req_s s;
    s = rnd_req(OP_SHARED_ALT);
    s.rs1_val = s.rs1_val & ~64'h3f;
    s.imm = 1'b1;
    s.low_bits = 13'h0;
    s.rd = {s.rd[4], 3'h0, s.rd[0]};
    s.asi = asi;
    return s;
  endfunction

  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(36));
    repeat (16) @(posedge MCLK);
    RESETN <= 1'b1;
    @(posedge MCLK);
    check(iss_ready, 1'b1, "ready after reset");
    wb(CTRL_OFS, 1'b0, 32'h0, q);
    check(q, 64'(CTRL_RESET), "control reset");
    wb(8'h3c, 1'b1, 32'hffffffff, q);
    wb(8'h3c, 1'b0, 32'h0, q);
    check(q, 64'h0, "unmapped read");
    $display("test registers done");
    for (int t = 0; t < 24; t++) begin
      stall <= t[1];
      run(rnd_req(t[0] ? OP_DOUBLE : OP_SINGLE), RES_OK);
    end
    $display("test single double done");
    r = rnd_req(OP_DOUBLE);
    r.rs1_val[2] = 1'b1;
    run(r, RES_DBL_MISAL);
    r.op = OP_SINGLE;
    run(r, RES_OK);
    r.rs1_val[1:0] = 2'h2;
    run(r, RES_MISALIGN);
    run(rnd_req(OP_QUAD), RES_ILLEGAL);
    r = rnd_req(OP_SINGLE);
    r.imm = 1'b0;
    r.low_bits[12:5] = 8'h01;
    run(r, RES_ILLEGAL);
    fef <= 1'b0;
    run(rnd_req(OP_SINGLE), RES_FLOAT_OFF);
    run(rnd_req(OP_QUAD), RES_ILLEGAL);
    fef <= 1'b1;
    pef <= 1'b0;
    run(blk(ASI_COMMIT_S), RES_FLOAT_OFF);
    pef <= 1'b1;
    wb(CTRL_OFS, 1'b1, 32'h6, q);
    run(rnd_req(OP_DOUBLE), RES_FLOAT_OFF);
    $display("test traps done");
    wb(CTRL_OFS, 1'b1, 32'h7, q);
    run(blk(ASI_BLK_AIUP), RES_OK);
    run(blk(ASI_BLK_AIUS), RES_OK);
    run(blk(ASI_BLK_AIUPL), RES_OK);
    run(blk(ASI_BLK_AIUSL), RES_OK);
    run(blk(ASI_COMMIT_P), RES_OK);
    run(blk(ASI_COMMIT_S), RES_OK);
    priv <= 1'b0;
    run(blk(ASI_BLK_AIUSL), RES_PRIV);
    run(blk(ASI_COMMIT_P), RES_OK);
    priv <= 1'b1;
    r = blk(ASI_BLK_AIUP);
    r.rs1_val[5] = 1'b1;
    run(r, RES_MISALIGN);
    r = blk(ASI_BLK_AIUP);
    r.rd = 5'h02;
    run(r, RES_ILLEGAL);
    r.asi = 8'h80;
    run(r, RES_OTHER_UNIT);
    cacheable <= 1'b0;
    run(blk(ASI_BLK_AIUS), RES_OK);
    wb(CTRL_OFS, 1'b1, 32'h5, q);
    run(blk(ASI_BLK_AIUS), RES_ILLEGAL);
    cacheable <= 1'b1;
    $display("test block done");
    r = blk(ASI_COMMIT_P);
    wa = r.rs1_val + 64'h20;
    wb(WATCH_LO_OFS, 1'b1, wa[31:0], q);
    wb(WATCH_HI_OFS, 1'b1, wa[63:32], q);
    wb(CTRL_OFS, 1'b1, 32'hf, q);
    run(r, RES_WATCH);
    wb(CTRL_OFS, 1'b1, 32'hb, q);
    run(r, RES_OK);
    wb(WATCH_LO_OFS, 1'b1, r.rs1_val[31:0], q);
    run(r, RES_WATCH);
    wb(STATUS_OFS, 1'b0, 32'h0, q);
    check(q[2:0], 64'(RES_WATCH), "last result");
    wb(STORE_CNT_OFS, 1'b0, 32'h0, q);
    check(q, 64'(ok_cnt), "store count");
    $display("test watch done");
    print_verdict();
  end
endmodule
`default_nettype wire
